// >>> logic/tlic_pkg.sv
// Package for the two-level interrupt controller: register offsets,
// field positions, reset values, vector addresses and the sync depth.
// Assumes an 8-bit register port and a 21-bit program counter.
package tlic_pkg;

	// Register port geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int PC_W   = 21;
	localparam int SRC_COUNT = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_INT_CTRL   = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_FLAG       = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_ENABLE     = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_PRIORITY   = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_SERVICE    = 3'h5;

	// Field positions
	localparam int PRIO_MODE_BIT   = 7;
	localparam int GLOBAL_HIGH_BIT = 7;
	localparam int GLOBAL_LOW_BIT  = 6;
	localparam int SVC_HIGH_BIT    = 0;
	localparam int SVC_LOW_BIT     = 1;

	// Reset values
	localparam logic [DATA_W-1:0] RST_RESET_CTRL = 8'h00;
	localparam logic [DATA_W-1:0] RST_INT_CTRL   = 8'h00;
	localparam logic [DATA_W-1:0] RST_FLAG       = 8'h00;
	localparam logic [DATA_W-1:0] RST_ENABLE     = 8'h00;
	localparam logic [DATA_W-1:0] RST_PRIORITY   = 8'hff;

	// Vector addresses
	localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW  = 21'h000018;

	// Instruction boundaries a request must persist before it is taken
	localparam int SYNC_BOUNDARIES = 2;

	// Which register a read or write selects
	typedef enum logic [2:0] {
		TLIC_SEL_NONE,
		TLIC_SEL_RESET_CTRL,
		TLIC_SEL_INT_CTRL,
		TLIC_SEL_FLAG,
		TLIC_SEL_ENABLE,
		TLIC_SEL_PRIORITY,
		TLIC_SEL_SERVICE
	} tlic_sel_t;

endpackage

// >>> logic/tlic_core.sv
// Two-level priority interrupt controller with compatibility mode.
// Assumes a core sequencer that pulses instr_boundary once per
// instruction cycle, offers its return address, pushes and loads the
// PC on our pulses, and pulses return_from_service for the return op.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each source has flag, enable, priority bits
// - High vector 000008h, low vector 000018h
// - High request preempts running low routine
// - No low request taken during high service
// - Priority mode only while reset-control bit7 set
// - Priority mode: bit7 high, bit6 low enable
// - Flag, enable, global enable set: vector now
// - Clearing source enable blocks only that source
// - Compatibility mode ignores priority bits
// - Compatibility: bit6 peripherals, bit7 all sources
// - Compatibility mode always vectors to 000008h
// - Acceptance clears the applicable global enable
// - Acceptance pushes return address, loads vector
// - Return op sets applicable global enable again; a return in an accept cycle is ignored
// - Pin event to vector: three-four cycles
// - Flags set regardless of any enable
module tlic_core #(
	parameter int                       NUM_SRC     = tlic_pkg::SRC_COUNT,
	parameter logic [NUM_SRC-1:0]       PERIPH_MASK = NUM_SRC'(8'hf0)
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       arst_n,
	// Register port
	input  wire logic [tlic_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [tlic_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [tlic_pkg::DATA_W-1:0] reg_rdata,
	// Interrupt sources
	input  wire logic [NUM_SRC-1:0]         src_event,
	// Core sequencer
	input  wire logic                       instr_boundary,
	input  wire logic [tlic_pkg::PC_W-1:0]  return_addr,
	input  wire logic                       return_from_service,
	output logic                            stack_push,
	output logic      [tlic_pkg::PC_W-1:0]  push_addr,
	output logic                            pc_load,
	output logic      [tlic_pkg::PC_W-1:0]  pc_vector
);

	// Register decode, used by both the write and the read path
	function automatic tlic_pkg::tlic_sel_t decode(
		input logic [tlic_pkg::ADDR_W-1:0] a);
		case (a)
			tlic_pkg::OFS_RESET_CTRL: decode = tlic_pkg::TLIC_SEL_RESET_CTRL;
			tlic_pkg::OFS_INT_CTRL:   decode = tlic_pkg::TLIC_SEL_INT_CTRL;
			tlic_pkg::OFS_FLAG:       decode = tlic_pkg::TLIC_SEL_FLAG;
			tlic_pkg::OFS_ENABLE:     decode = tlic_pkg::TLIC_SEL_ENABLE;
			tlic_pkg::OFS_PRIORITY:   decode = tlic_pkg::TLIC_SEL_PRIORITY;
			tlic_pkg::OFS_SERVICE:    decode = tlic_pkg::TLIC_SEL_SERVICE;
			default:                  decode = tlic_pkg::TLIC_SEL_NONE;
		endcase
	endfunction

	// State
	logic [tlic_pkg::DATA_W-1:0] rst_ctrl_reg;
	logic [tlic_pkg::DATA_W-1:0] int_ctrl_reg;
	logic [NUM_SRC-1:0]          flag_reg;
	logic [NUM_SRC-1:0]          enable_reg;
	logic [NUM_SRC-1:0]          prio_reg;
	logic                        svc_high_reg;
	logic                        svc_low_reg;
	logic [tlic_pkg::SYNC_BOUNDARIES-1:0] sync_reg;

	// Combinational terms
	tlic_pkg::tlic_sel_t wsel;
	logic [NUM_SRC-1:0]  active;
	logic                prio_mode;
	logic                gie_high;
	logic                gie_low;
	logic                req_high;
	logic                req_low;
	logic                req_any;
	logic                accept;
	logic                take_high;

	assign wsel      = decode(reg_addr);
	assign prio_mode = rst_ctrl_reg[tlic_pkg::PRIO_MODE_BIT];
	assign gie_high  = int_ctrl_reg[tlic_pkg::GLOBAL_HIGH_BIT];
	assign gie_low   = int_ctrl_reg[tlic_pkg::GLOBAL_LOW_BIT];
	// A source counts only with its own enable set
	assign active    = flag_reg & enable_reg;

	// Request qualification for both modes
	always_comb begin
		if (prio_mode) begin
			req_high = gie_high && |(active & prio_reg);
			// Low level is held off for the whole high routine
			req_low  = gie_low && !svc_high_reg
				&& |(active & ~prio_reg);
		end else begin
			// Priority bits play no part here
			req_high = gie_high && (|(active & ~PERIPH_MASK)
				|| (gie_low && |(active & PERIPH_MASK)));
			req_low  = 1'b0;
		end
	end

	assign req_any   = req_high || req_low;
	// A request must persist over the sync boundaries, which lands the
	// vector three to four instruction cycles after the event
	assign accept    = instr_boundary && sync_reg[tlic_pkg::SYNC_BOUNDARIES-1]
		&& req_any && !pc_load;
	assign take_high = req_high;

	// Boundary pipeline; a request that drops restarts it
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync_reg <= '0;
		end else if (!req_any || accept) begin
			sync_reg <= '0;
		end else if (instr_boundary) begin
			sync_reg <= {sync_reg[tlic_pkg::SYNC_BOUNDARIES-2:0], 1'b1};
		end
	end

	// Per-source bits; an event beats a clearing write in the same cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flag_reg   <= NUM_SRC'(tlic_pkg::RST_FLAG);
			enable_reg <= NUM_SRC'(tlic_pkg::RST_ENABLE);
			prio_reg   <= NUM_SRC'(tlic_pkg::RST_PRIORITY);
		end else begin
			if (reg_wr && wsel == tlic_pkg::TLIC_SEL_FLAG) begin
				flag_reg <= NUM_SRC'(reg_wdata) | src_event;
			end else begin
				flag_reg <= flag_reg | src_event;
			end
			if (reg_wr && wsel == tlic_pkg::TLIC_SEL_ENABLE) begin
				enable_reg <= NUM_SRC'(reg_wdata);
			end
			if (reg_wr && wsel == tlic_pkg::TLIC_SEL_PRIORITY) begin
				prio_reg <= NUM_SRC'(reg_wdata);
			end
		end
	end

	// Mode register; the mode bit starts clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_ctrl_reg <= tlic_pkg::RST_RESET_CTRL;
		end else if (reg_wr && wsel == tlic_pkg::TLIC_SEL_RESET_CTRL) begin
			rst_ctrl_reg <= reg_wdata;
		end
	end

	// Global enables: hardware clear or set outranks a software write,
	// otherwise a write in the accept cycle could cause a re-entry
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			int_ctrl_reg <= tlic_pkg::RST_INT_CTRL;
		end else if (accept) begin
			if (take_high || !prio_mode) begin
				int_ctrl_reg[tlic_pkg::GLOBAL_HIGH_BIT] <= 1'b0;
			end else begin
				int_ctrl_reg[tlic_pkg::GLOBAL_LOW_BIT] <= 1'b0;
			end
		end else if (return_from_service) begin
			if (prio_mode && !svc_high_reg && svc_low_reg) begin
				int_ctrl_reg[tlic_pkg::GLOBAL_LOW_BIT] <= 1'b1;
			end else begin
				int_ctrl_reg[tlic_pkg::GLOBAL_HIGH_BIT] <= 1'b1;
			end
		end else if (reg_wr && wsel == tlic_pkg::TLIC_SEL_INT_CTRL) begin
			int_ctrl_reg <= reg_wdata;
		end
	end

	// Which level is in service; high may nest over low
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			svc_high_reg <= 1'b0;
			svc_low_reg  <= 1'b0;
		end else if (accept) begin
			if (take_high) begin
				svc_high_reg <= 1'b1;
			end else begin
				svc_low_reg <= 1'b1;
			end
		end else if (return_from_service) begin
			if (svc_high_reg) begin
				svc_high_reg <= 1'b0;
			end else begin
				svc_low_reg <= 1'b0;
			end
		end
	end

	// Core hand-off: push and load in the cycle after acceptance
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stack_push <= 1'b0;
			pc_load    <= 1'b0;
			push_addr  <= '0;
			pc_vector  <= '0;
		end else begin
			stack_push <= accept;
			pc_load    <= accept;
			if (accept) begin
				push_addr <= return_addr;
				// Compatibility mode only raises the high request
				pc_vector <= take_high ? tlic_pkg::VEC_HIGH
					: tlic_pkg::VEC_LOW;
			end
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (decode(reg_addr))
				tlic_pkg::TLIC_SEL_RESET_CTRL: reg_rdata <= rst_ctrl_reg;
				tlic_pkg::TLIC_SEL_INT_CTRL:   reg_rdata <= int_ctrl_reg;
				tlic_pkg::TLIC_SEL_FLAG:       reg_rdata <= 8'(flag_reg);
				tlic_pkg::TLIC_SEL_ENABLE:     reg_rdata <= 8'(enable_reg);
				tlic_pkg::TLIC_SEL_PRIORITY:   reg_rdata <= 8'(prio_reg);
				tlic_pkg::TLIC_SEL_SERVICE:
					reg_rdata <= 8'({svc_low_reg, svc_high_reg});
				default:                       reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// Checks on the controller's own behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	flag_capture_a: assert property (
		src_event != '0 |=> (flag_reg & $past(src_event)) == $past(src_event))
		else $error("event did not set its flag");

	compat_vector_a: assert property (
		pc_load && !$past(prio_mode) |-> pc_vector == tlic_pkg::VEC_HIGH)
		else $error("compatibility vector is not the high address");

	low_vector_a: assert property (
		pc_load && $rose(svc_low_reg) |-> pc_vector == tlic_pkg::VEC_LOW)
		else $error("low entry did not load the low vector");

	no_low_nest_a: assert property (
		svc_high_reg |=> !$rose(svc_low_reg))
		else $error("low level entered during high service");

	entry_clear_a: assert property (
		pc_load && $rose(svc_high_reg) |-> !gie_high)
		else $error("high enable still set after entry");

	push_pair_a: assert property (
		accept |=> stack_push && pc_load && push_addr == $past(return_addr)
			##1 !pc_load)
		else $error("push and load not paired with acceptance");

	return_enable_a: assert property (
		return_from_service && !accept && svc_high_reg |=> gie_high)
		else $error("return did not restore the high enable");

	enable_gate_a: assert property (
		pc_load |-> $past(|active))
		else $error("vector taken without an enabled source");

	high_first_a: assert property (
		accept && req_high && req_low |=> pc_vector == tlic_pkg::VEC_HIGH)
		else $error("low level won over a pending high request");

	sync_wait_a: assert property (
		accept |-> $past(req_any, 2) && instr_boundary)
		else $error("request taken without its sync wait");

	// Enable bookkeeping on entry and return, per level and mode
	low_clear_a: assert property (
		accept && !take_high |=> !gie_low)
		else $error("low enable still set after low entry");

	compat_clear_a: assert property (
		accept && !prio_mode |=> !gie_high)
		else $error("single enable still set after entry");

	low_return_a: assert property (
		return_from_service && !accept && prio_mode
			&& !svc_high_reg && svc_low_reg
			|=> gie_low && !svc_low_reg)
		else $error("return did not restore the low enable");

	// Gating: an entry needs the enable that its level asks for
	low_gate_a: assert property (
		accept && !take_high
			|-> prio_mode && gie_low && !svc_high_reg)
		else $error("low entry without its level enable");

	high_gate_a: assert property (
		accept && take_high |-> gie_high)
		else $error("high entry without the high enable");

	compat_single_a: assert property (
		accept && !prio_mode |=> svc_high_reg && !$rose(svc_low_reg))
		else $error("compatibility entry used the low level");

	preempt_keep_a: assert property (
		accept && take_high |=> svc_high_reg && $stable(svc_low_reg))
		else $error("high entry disturbed the low routine state");

	// Flags fall only by a software write; the core sees one push each
	flag_hold_a: assert property (
		!(reg_wr && wsel == tlic_pkg::TLIC_SEL_FLAG)
			|=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
		else $error("flag dropped without a write");

	push_once_a: assert property (
		stack_push |=> !stack_push)
		else $error("push pulse longer than one cycle");

	vector_set_a: assert property (
		pc_load |-> pc_vector == tlic_pkg::VEC_HIGH
			|| pc_vector == tlic_pkg::VEC_LOW)
		else $error("vector is neither the high nor the low address");

	mode_low_a: assert property (
		!prio_mode |-> !req_low)
		else $error("low request outside priority mode");

	preempt_c: cover property (svc_low_reg && $rose(svc_high_reg));
	high_first_c: cover property (accept && req_high && req_low);
	low_entry_c: cover property ($rose(svc_low_reg));
	compat_entry_c: cover property (accept && !prio_mode);
	return_c: cover property (return_from_service && svc_low_reg);

endmodule

`default_nettype wire

// >>> dv/tlic_seq_model.sv
// Core sequencer model: instruction boundaries, program counter, returns.
// Assumes the controller answers an accept with stack_push and pc_load.
`timescale 1ns/1ps
`default_nettype none
module tlic_seq_model (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      arst_n,
	// Controller side
	input  wire logic                      pc_load,
	input  wire logic [tlic_pkg::PC_W-1:0] pc_vector,
	output logic                           instr_boundary,
	output logic      [tlic_pkg::PC_W-1:0] return_addr,
	output logic                           return_from_service
);
	logic [1:0] phase_reg;
	logic       ret_req;
	int         ret_asked;
	int         ret_done;
	// Four clocks per instruction, boundary on the last one
	assign instr_boundary = (phase_reg == 2'h3);
	// A return is pending while asks outnumber retired returns
	assign ret_req = (ret_asked != ret_done);
	// A return op only retires on an instruction boundary
	assign return_from_service = ret_req & instr_boundary;
	// Program counter steps per instruction and jumps on a vector load
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= 2'h0;
			return_addr <= 21'h000100;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			if (pc_load)
				return_addr <= pc_vector;
			else if (instr_boundary)
				return_addr <= return_addr + 21'h000001;
		end
	end
	// Retired returns; each ask fires exactly once on a boundary
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			ret_done <= 0;
		else if (return_from_service)
			ret_done <= ret_done + 1;
	end
	task automatic do_return();
		@(posedge clock);
		ret_asked <= ret_asked + 1;
	endtask
endmodule
`default_nettype wire

// >>> dv/tlic_core_tb_top.sv
// Testbench for the interrupt controller: registers, vectors, returns.
// Assumes the sequencer model supplies boundaries and return ops.
`timescale 1ns/1ps
`default_nettype none
module tlic_core_tb_top;
	localparam logic [2:0] RC = tlic_pkg::OFS_RESET_CTRL;
	localparam logic [2:0] IC = tlic_pkg::OFS_INT_CTRL;
	localparam logic [2:0] FL = tlic_pkg::OFS_FLAG;
	localparam logic [2:0] EN = tlic_pkg::OFS_ENABLE;
	localparam logic [2:0] PR = tlic_pkg::OFS_PRIORITY;
	localparam logic [2:0] SV = tlic_pkg::OFS_SERVICE;
	logic        clock, arst_n, reg_wr, reg_rd, rd_d;
	logic        stack_push, pc_load, ib, rfs;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, src_event, pat;
	logic [20:0] ret, ret_d, push_addr, pc_vector;
	logic [31:0] seed;
	logic [7:0]  q_rd[$];
	logic [20:0] q_vec[$];
	int          n_mismatch, tests_run, n_push, cyc;
	time         t_ev, t_push;

	tlic_core DUT (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .src_event(src_event),
		.instr_boundary(ib), .return_addr(ret),
		.return_from_service(rfs), .stack_push(stack_push),
		.push_addr(push_addr), .pc_load(pc_load), .pc_vector(pc_vector));
	tlic_seq_model core (.clock(clock), .arst_n(arst_n), .pc_load(pc_load),
		.pc_vector(pc_vector), .instr_boundary(ib), .return_addr(ret),
		.return_from_service(rfs));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// Plain single-register writes, never a block move while enabled
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		q_rd.push_back(e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask
	task automatic ev(input logic [7:0] m);
		@(posedge clock);
		src_event <= m;
		t_ev = $time;
		@(posedge clock);
		src_event <= 8'h00;
	endtask
	// Note the vector, then wait a bounded time for the load
	task automatic vec(input logic [20:0] v);
		int n;
		n = n_push;
		q_vec.push_back(v);
		for (int i = 0; i < 60 && n_push == n; i++)
			@(posedge clock);
		check(32'(n_push - n), 32'h1);
	endtask
	task automatic quiet();
		repeat (24) @(posedge clock);
	endtask
	task automatic ret_op();
		core.do_return();
		repeat (6) @(posedge clock);
	endtask

	// Free-running 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Scoreboard: read data and vector loads against the queued notes
	always @(posedge clock) begin
		cyc <= cyc + 1;
		rd_d <= reg_rd;
		ret_d <= ret;
		if (rd_d)
			check(32'(reg_rdata), 32'(q_rd.pop_front()));
		if (stack_push !== 1'b0) begin
			n_push++;
			t_push = $time;
			check(32'(pc_vector), q_vec.size() ? 32'(q_vec.pop_front()) : '1);
			check(32'(push_addr), 32'(ret_d));
			check(32'(pc_load), 32'h1);
		end
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	// Main sequence; software clears the serviced flag before every return
	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rd_d = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		src_event = 8'h00;
		cyc = 0;
		seed = 32'd4108;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		wr(SV, 8'hff);
		wr(3'h6, 8'hff);
		for (int a = 0; a < 8; a++)
			rd(3'(a), (a == 4) ? 8'hff : 8'h00);
		done("reset");
		seed = xs(seed);
		pat = seed[7:0] | 8'h01;
		ev(pat);
		quiet();
		rd(FL, pat);
		wr(FL, 8'h00);
		done("flags");
		wr(EN, 8'hff);
		wr(PR, 8'h00);
		wr(IC, 8'h80);
		ev(8'h01);
		vec(tlic_pkg::VEC_HIGH);
		check(32'((t_push - t_ev) inside {[110:140]}), 32'h1);
		rd(IC, 8'h00);
		rd(SV, 8'h01);
		wr(FL, 8'h00);
		ret_op();
		rd(IC, 8'h80);
		ev(8'h10);
		quiet();
		wr(IC, 8'hc0);
		vec(tlic_pkg::VEC_HIGH);
		wr(FL, 8'h00);
		ret_op();
		done("compat");
		wr(RC, 8'h80);
		wr(PR, 8'h01);
		wr(EN, 8'h03);
		ev(8'h02);
		vec(tlic_pkg::VEC_LOW);
		rd(IC, 8'h80);
		ev(8'h01);
		vec(tlic_pkg::VEC_HIGH);
		rd(SV, 8'h03);
		wr(FL, 8'h00);
		ret_op();
		rd(IC, 8'h80);
		ret_op();
		rd(IC, 8'hc0);
		done("preempt");
		ev(8'h03);
		vec(tlic_pkg::VEC_HIGH);
		quiet();
		wr(FL, 8'h02);
		ret_op();
		vec(tlic_pkg::VEC_LOW);
		wr(FL, 8'h00);
		ret_op();
		done("both");
		wr(EN, 8'h02);
		ev(8'h03);
		vec(tlic_pkg::VEC_LOW);
		quiet();
		wr(FL, 8'h00);
		ret_op();
		done("mask");
		conclude();
	end
endmodule
`default_nettype wire
